// [common/sffc_regs.vh]
`ifndef SFFC_REGS_VH
`define SFFC_REGS_VH

// serial opcodes and fixed values
`define SFFC_OP_FAST_READ     8'h0B
`define SFFC_FR_OPCODE_RST    8'h3B
`define SFFC_DUMMY_BYTE       8'h00
`define SFFC_DONT_CARE        8'hFF

// boot signature search
`define SFFC_BOOT_SIG_ADDR    24'h00FFFA
`define SFFC_BOOT_SIG         32'h32444655
`define SFFC_BOOT_SIG_LAST    2'h3
`define SFFC_EXEC_START       24'h000000

// dual mode address forcing
`define SFFC_DUAL_ADDR_ZERO   7'h00

// buffers
`define SFFC_CACHE_BYTES      6'h20
`define SFFC_CMD_BUF_BYTES    4'h8

// serial clock half periods in mclk cycles, per latched speed strap
`define SFFC_HALF_SLOW        3'h4
`define SFFC_HALF_FAST        3'h2

// index of the last bit of a data byte, single and dual
`define SFFC_LAST_BIT_SINGLE  3'h7
`define SFFC_LAST_BIT_DUAL    3'h3

`endif

// [rtl/sffc_ctrl.v]
`timescale 1ns/10ps
`include "sffc_regs.vh"

module sffc_ctrl (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        fetch_req,
  input  wire [23:0] fetch_addr,
  input  wire        fetch_dual,
  output reg         fetch_rdy,
  output reg  [7:0]  fetch_data,
  output reg         boot_done,
  output reg         ext_rom_en,
  output reg  [23:0] exec_start_addr,
  input  wire        flash_port_disable_set,
  output reg         flash_port_disabled,
  input  wire        fr_opcode_wr,
  input  wire [7:0]  fr_opcode_data,
  input  wire        cmd_buf_wr,
  input  wire [2:0]  cmd_buf_idx,
  input  wire [7:0]  cmd_buf_data,
  input  wire [3:0]  command_length,
  input  wire        ctl_go_set,
  output reg         ctl_busy,
  input  wire [2:0]  resp_rd_idx,
  output reg  [7:0]  resp_rd_data,
  input  wire        suspend,
  output reg         flash_cs_n,
  output reg         flash_sck,
  output wire        flash_do_o,
  output reg         flash_do_oe,
  input  wire        flash_do_i,
  input  wire        flash_serial_in,
  input  wire        flash_speed_strap_i,
  output reg         flash_speed_strap_o,
  output reg         flash_speed_strap_oe,
  output reg         speed_fast
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPC   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_DUMMY = 3'h3;
  localparam [2:0] ST_DATA  = 3'h4;
  localparam [2:0] ST_HOLD  = 3'h5;
  localparam [2:0] ST_CMD   = 3'h6;

  reg        do_s1;
  reg        do_s2;
  reg        di_s1;
  reg        di_s2;
  reg        strap_s1;
  reg        strap_s2;
  reg        strap_done_reg;
  reg [2:0]  state_reg;
  reg [2:0]  half_cnt_reg;
  reg [2:0]  bit_cnt_reg;
  reg [3:0]  byte_cnt_reg;
  reg [7:0]  shift_reg;
  reg [7:0]  rx_reg;
  reg        dual_reg;
  reg [23:0] addr_tx_reg;
  reg [23:0] last_addr_reg;
  reg [7:0]  fast_read_opcode_reg;
  reg [23:0] cache_base_reg;
  reg [5:0]  cache_len_reg;
  reg [7:0]  cache_mem [0:31];
  reg [7:0]  cmd_buf [0:7];
  reg [7:0]  response_buffer [0:7];
  reg [3:0]  cmd_len_reg;
  reg        boot_active_reg;
  reg [1:0]  boot_idx_reg;
  reg [23:0] sig_reg;
  reg        retry_reg;
  reg [24:0] retry_req_reg;

  wire [2:0]  half_m1   = (speed_fast ? `SFFC_HALF_FAST : `SFFC_HALF_SLOW) - 3'h1;
  wire        tick      = (half_cnt_reg == 3'h0);
  wire        shifting  = (state_reg == ST_OPC) || (state_reg == ST_ADDR) ||
                          (state_reg == ST_DUMMY) || (state_reg == ST_DATA) ||
                          (state_reg == ST_CMD);
  wire        data_dual = dual_reg && (state_reg == ST_DATA);
  wire        last_bit  = (bit_cnt_reg ==
                           (data_dual ? `SFFC_LAST_BIT_DUAL : `SFFC_LAST_BIT_SINGLE));
  wire        byte_done = shifting && tick && flash_sck && last_bit;
  // io1 (flash output) carries the higher bit of each pair
  wire [7:0]  rx_shift  = data_dual ? {rx_reg[5:0], di_s2, do_s2} : {rx_reg[6:0], di_s2};
  wire        req_w     = boot_active_reg ? 1'b1 : (fetch_req || retry_reg);
  wire [23:0] addr_w    = boot_active_reg ? (`SFFC_BOOT_SIG_ADDR + {22'h0, boot_idx_reg}) :
                          retry_reg ? retry_req_reg[23:0] : fetch_addr;
  wire        dual_w    = boot_active_reg ? 1'b0 : (retry_reg ? retry_req_reg[24] : fetch_dual);
  wire [23:0] cache_off = addr_w - cache_base_reg;
  wire        cache_hit = !boot_active_reg && (cache_len_reg != 6'h00) &&
                          (cache_off < {18'h0, cache_len_reg});
  wire [23:0] next_seq  = last_addr_reg + 24'h1;
  wire [3:0]  next_idx  = byte_cnt_reg + 4'h1;
  wire [3:0]  resp_idx  = byte_cnt_reg - 4'h1;

  assign flash_do_o = shift_reg[7];

  // first stage of each synchroniser feeds only the second
  always @(posedge mclk) begin
    do_s1    <= flash_do_i;
    do_s2    <= do_s1;
    di_s1    <= flash_serial_in;
    di_s2    <= di_s1;
    strap_s1 <= flash_speed_strap_i;
    strap_s2 <= strap_s1;
  end

  // strap pin: released in reset, latched once after release
  always @(posedge mclk) begin
    if (!rst_n) begin
      strap_done_reg       <= 1'b0;
      speed_fast           <= 1'b0;
      flash_speed_strap_o  <= 1'b0;
      flash_speed_strap_oe <= 1'b0;
    end else begin
      if (!strap_done_reg) begin
        strap_done_reg <= 1'b1;
        speed_fast     <= strap_s2;
      end
      flash_speed_strap_o  <= suspend ? 1'b0 : speed_fast;
      flash_speed_strap_oe <= strap_done_reg && !(suspend && speed_fast);
    end
  end

  // software side registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      fast_read_opcode_reg <= `SFFC_FR_OPCODE_RST;
      flash_port_disabled  <= 1'b0;
    end else begin
      if (fr_opcode_wr)
        fast_read_opcode_reg <= fr_opcode_data;
      if (flash_port_disable_set)
        flash_port_disabled <= 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (cmd_buf_wr)
      cmd_buf[cmd_buf_idx] <= cmd_buf_data;
    resp_rd_data <= response_buffer[resp_rd_idx];
  end

  // fetch, boot and command sequencer
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg       <= ST_IDLE;
      flash_cs_n      <= 1'b1;
      flash_sck       <= 1'b0;
      flash_do_oe     <= 1'b0;
      half_cnt_reg    <= 3'h0;
      bit_cnt_reg     <= 3'h0;
      byte_cnt_reg    <= 4'h0;
      shift_reg       <= 8'h00;
      rx_reg          <= 8'h00;
      dual_reg        <= 1'b0;
      addr_tx_reg     <= 24'h0;
      last_addr_reg   <= 24'h0;
      cache_base_reg  <= 24'h0;
      cache_len_reg   <= 6'h00;
      cmd_len_reg     <= 4'h0;
      ctl_busy        <= 1'b0;
      fetch_rdy       <= 1'b0;
      fetch_data      <= 8'h00;
      boot_active_reg <= 1'b1;
      boot_idx_reg    <= 2'h0;
      sig_reg         <= 24'h0;
      retry_reg       <= 1'b0;
      boot_done       <= 1'b0;
      ext_rom_en      <= 1'b0;
      exec_start_addr <= 24'h0;
    end else begin
      fetch_rdy <= 1'b0;
      retry_reg <= 1'b0;
      // launch set wins over the self-clear below
      if (ctl_go_set)
        ctl_busy <= 1'b1;
      if (shifting) begin
        if (tick) begin
          half_cnt_reg <= half_m1;
          if (!flash_sck) begin
            flash_sck <= 1'b1;
          end else begin
            flash_sck   <= 1'b0;
            rx_reg      <= rx_shift;
            shift_reg   <= {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
        end else begin
          half_cnt_reg <= half_cnt_reg - 3'h1;
        end
      end
      case (state_reg)
        ST_IDLE: begin
          flash_cs_n  <= 1'b1;
          flash_do_oe <= 1'b0;
          if (!strap_done_reg) begin
            state_reg <= ST_IDLE;
          end else if (flash_port_disabled) begin
            if (boot_active_reg) begin
              boot_active_reg <= 1'b0;
              boot_done       <= 1'b1;
            end
            if (ctl_busy && !ctl_go_set)
              ctl_busy <= 1'b0;
          end else if (ctl_busy && !boot_active_reg) begin
            if (command_length == 4'h0) begin
              ctl_busy <= ctl_go_set;
            end else begin
              cmd_len_reg  <= command_length;
              flash_cs_n   <= 1'b0;
              flash_do_oe  <= 1'b1;
              shift_reg    <= cmd_buf[0];
              byte_cnt_reg <= 4'h0;
              bit_cnt_reg  <= 3'h0;
              half_cnt_reg <= half_m1;
              state_reg    <= ST_CMD;
            end
          end else if (req_w && (boot_active_reg || boot_done)) begin
            if (cache_hit) begin
              fetch_data    <= cache_mem[addr_w[4:0]];
              fetch_rdy     <= 1'b1;
              last_addr_reg <= addr_w;
            end else begin
              flash_cs_n     <= 1'b0;
              flash_do_oe    <= 1'b1;
              dual_reg       <= dual_w;
              shift_reg      <= dual_w ? fast_read_opcode_reg : `SFFC_OP_FAST_READ;
              addr_tx_reg    <= dual_w ? {`SFFC_DUAL_ADDR_ZERO, addr_w[16:0]} : addr_w;
              last_addr_reg  <= addr_w;
              cache_base_reg <= addr_w;
              cache_len_reg  <= 6'h00;
              bit_cnt_reg    <= 3'h0;
              half_cnt_reg   <= half_m1;
              state_reg      <= ST_OPC;
            end
          end
        end
        ST_OPC: begin
          if (byte_done) begin
            shift_reg    <= addr_tx_reg[23:16];
            byte_cnt_reg <= 4'h0;
            bit_cnt_reg  <= 3'h0;
            state_reg    <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= next_idx;
            if (byte_cnt_reg == 4'h0) begin
              shift_reg <= addr_tx_reg[15:8];
            end else if (byte_cnt_reg == 4'h1) begin
              shift_reg <= addr_tx_reg[7:0];
            end else begin
              shift_reg <= `SFFC_DUMMY_BYTE;
              state_reg <= ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          if (byte_done) begin
            bit_cnt_reg <= 3'h0;
            flash_do_oe <= !dual_reg;
            state_reg   <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (byte_done) begin
            cache_mem[last_addr_reg[4:0]] <= rx_shift;
            if (cache_len_reg == `SFFC_CACHE_BYTES)
              cache_base_reg <= cache_base_reg + 24'h1;
            else
              cache_len_reg <= cache_len_reg + 6'h01;
            if (boot_active_reg) begin
              sig_reg      <= {sig_reg[15:0], rx_shift};
              boot_idx_reg <= boot_idx_reg + 2'h1;
              if (boot_idx_reg == `SFFC_BOOT_SIG_LAST) begin
                boot_active_reg <= 1'b0;
                boot_done       <= 1'b1;
                ext_rom_en      <= ({sig_reg, rx_shift} == `SFFC_BOOT_SIG);
                exec_start_addr <= `SFFC_EXEC_START;
                flash_cs_n      <= 1'b1;
                state_reg       <= ST_IDLE;
              end else begin
                state_reg <= ST_HOLD;
              end
            end else begin
              fetch_data <= rx_shift;
              fetch_rdy  <= 1'b1;
              state_reg  <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // chip select stays low between sequential bytes, clock parked
          if (flash_port_disabled || (ctl_busy && !boot_active_reg)) begin // launch ends the read
            flash_cs_n <= 1'b1;
            state_reg  <= ST_IDLE;
          end else if (req_w) begin
            if (addr_w == next_seq) begin
              last_addr_reg <= addr_w;
              bit_cnt_reg   <= 3'h0;
              half_cnt_reg  <= half_m1;
              state_reg     <= ST_DATA;
            end else begin
              // the new request is retried from idle one cycle later
              flash_cs_n    <= 1'b1;
              state_reg     <= ST_IDLE;
              retry_reg     <= 1'b1;
              retry_req_reg <= {fetch_dual, fetch_addr};
            end
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            // input captured even for erases; software ignores it
            if ((byte_cnt_reg != 4'h0) && (resp_idx < `SFFC_CMD_BUF_BYTES))
              response_buffer[resp_idx[2:0]] <= rx_shift;
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= next_idx;
            if (next_idx == cmd_len_reg) begin
              flash_cs_n  <= 1'b1;
              flash_do_oe <= 1'b0;
              ctl_busy    <= ctl_go_set;
              state_reg   <= ST_IDLE;
            end else if (next_idx < `SFFC_CMD_BUF_BYTES) begin
              shift_reg <= cmd_buf[next_idx[2:0]];
            end else begin
              shift_reg <= `SFFC_DONT_CARE;
            end
          end
        end
        default: begin
          flash_cs_n <= 1'b1;
          state_reg  <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sffc_ctrl

// [sim/sffc_ctrl_bench.sv]
`timescale 1ns/10ps
module sffc_ctrl_bench;
  reg         mclk, rst_n, fetch_req, fetch_dual, fr_opcode_wr, cmd_buf_wr, ctl_go_set;
  reg         suspend, flash_port_disable_set, strap_drv;
  reg  [23:0] fetch_addr;
  reg  [7:0]  fr_opcode_data, cmd_buf_data, o;
  reg  [2:0]  cmd_buf_idx, resp_rd_idx;
  reg  [3:0]  command_length;
  wire        fetch_rdy, boot_done, ext_rom_en, flash_port_disabled, ctl_busy, flash_cs_n;
  wire        flash_sck, flash_do_o, flash_do_oe, flash_serial_in, io0_drv, speed_fast;
  wire        flash_speed_strap_o, flash_speed_strap_oe;
  wire [7:0]  fetch_data, resp_rd_data;
  wire [23:0] exec_start_addr;
  wire        flash_do_i = flash_do_oe ? flash_do_o : io0_drv;
  wire        flash_speed_strap_i = flash_speed_strap_oe ? flash_speed_strap_o : strap_drv;
  integer     fail_count, tests_run, c, i, f;
  sffc_ctrl i_sffc_ctrl (.*);
  sffc_flash_model i_sffc_flash_model (.flash_cs_n(flash_cs_n), .flash_sck(flash_sck),
    .flash_do_o(flash_do_o), .dual(fetch_dual), .serial_in(flash_serial_in), .io0(io0_drv));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input ok, input string m);
    begin
      tests_run = tests_run + 1;
      if (ok !== 1'b1) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0t %s", $time, m);
      end
    end
  endtask
  task reset_run(input s, input sp);
    begin
      @(posedge mclk);
      rst_n <= 1'b0;
      strap_drv <= s;
      suspend <= sp;
      repeat (10) @(posedge mclk);
      chk(flash_cs_n === 1'b1 && flash_speed_strap_oe === 1'b0, "reset pins");
      rst_n <= 1'b1;
      c = 0;
      while (boot_done !== 1'b1 && c < 3000) begin
        @(posedge mclk);
        c = c + 1;
      end
      repeat (4) @(posedge mclk);
      #1;
      chk(ext_rom_en === 1'b1 && exec_start_addr === 24'h000000, "boot");
      chk(i_sffc_flash_model.ad === 24'h00FFFA && flash_port_disabled === 1'b0, "sig");
      chk(speed_fast === s && flash_speed_strap_oe === !(s && sp), "strap");
    end
  endtask
  // response wait counts edges after the taking edge
  task fetch(input [23:0] a, input d);
    begin
      @(posedge mclk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      fetch_dual <= d;
      @(posedge mclk);
      fetch_req <= 1'b0;
      #1;
      c = 0;
      while (fetch_rdy !== 1'b1 && c < 3000) begin
        @(posedge mclk);
        #1;
        c = c + 1;
      end
    end
  endtask
  task t_fetch;
    begin
      f = i_sffc_flash_model.frames;
      fetch(24'h001234, 1'b0);
      chk(fetch_data === i_sffc_flash_model.mem(24'h001234), "miss");
      chk(i_sffc_flash_model.op === 8'h0B && i_sffc_flash_model.ad === 24'h001234, "hdr");
      fetch(24'h001235, 1'b0);
      chk(fetch_data === 8'h6F && flash_cs_n === 1'b0 && c > 60, "seq");
      fetch(24'h001234, 1'b0);
      chk(c === 1 && fetch_data === 8'h6E, "rehit");
      fetch(24'h001235, 1'b0);
      chk(c === 0 && fetch_data === 8'h6F && i_sffc_flash_model.frames === f + 1, "hit");
      for (i = 0; i < 34; i = i + 1) fetch(24'h002000 + i, 1'b0);
      chk(i_sffc_flash_model.frames === f + 2 && fetch_data === 8'h7B, "run");
      fetch(24'h002021, 1'b0);
      chk(i_sffc_flash_model.frames === f + 2 && fetch_data === 8'h7B, "tail");
      fetch(24'h002001, 1'b0);
      chk(i_sffc_flash_model.frames === f + 3 && fetch_data === 8'h5B, "aged");
    end
  endtask
  task t_dual;
    begin
      @(posedge mclk);
      fr_opcode_wr <= 1'b1;
      fr_opcode_data <= 8'h3C;
      @(posedge mclk);
      fr_opcode_wr <= 1'b0;
      fetch(24'hFF0055, 1'b1);
      chk(i_sffc_flash_model.op === 8'h3C && i_sffc_flash_model.ad === 24'h010055, "dhdr");
      chk(fetch_data === 8'h0F, "dual");
      fetch(24'hFF0056, 1'b1);
      chk(fetch_data === 8'h0C && c > 28 && c < 40, "dseq");
    end
  endtask
  task cmd(input [3:0] len, input [63:0] bytes);
    integer j;
    begin
      fetch_dual <= 1'b0;
      for (j = 0; j < 8; j = j + 1) begin
        @(posedge mclk);
        cmd_buf_wr <= 1'b1;
        cmd_buf_idx <= j[2:0];
        cmd_buf_data <= bytes[63 - 8 * j -: 8];
      end
      @(posedge mclk);
      cmd_buf_wr <= 1'b0;
      command_length <= len;
      ctl_go_set <= 1'b1;
      @(posedge mclk);
      ctl_go_set <= 1'b0;
      j = 0;
      @(posedge mclk);
      #1;
      while (ctl_busy === 1'b1 && j < 9000) begin
        @(posedge mclk);
        #1;
        j = j + 1;
      end
      chk(flash_cs_n === 1'b1 && ctl_busy === 1'b0, "cmd end");
      chk(i_sffc_flash_model.n === 8 * len, "clocks");
    end
  endtask
  task t_cmd;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        o = (i == 0) ? 8'h20 : (i == 1) ? 8'h52 : 8'hD8;
        cmd(4'h4, {o, 24'h012345, 32'h0});
        chk(i_sffc_flash_model.rx[31:0] === {o, 24'h012345}, "erase");
      end
      cmd(4'h5, {8'h02, 24'h00ABCD, 8'hC3, 24'h0});
      chk(i_sffc_flash_model.rx[39:0] === 40'h0200ABCDC3, "program");
      cmd(4'h1, {8'h06, 56'h0});
      chk(i_sffc_flash_model.rx[7:0] === 8'h06, "single");
      cmd(4'hA, 64'h9F11223344556677);
      chk(i_sffc_flash_model.rx === 64'h2233445566_77FFFF, "pad");
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge mclk);
        resp_rd_idx <= i[2:0];
        @(posedge mclk);
        #1;
        chk(resp_rd_data === 8'hB0 + i[7:0], "resp");
      end
    end
  endtask
  task t_disable;
    begin
      @(posedge mclk);
      flash_port_disable_set <= 1'b1;
      @(posedge mclk);
      flash_port_disable_set <= 1'b0;
      fetch(24'h003000, 1'b0);
      chk(c === 3000 && flash_port_disabled === 1'b1, "disabled");
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // whole run is about 10k cycles, well under the 80k-cycle limit
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    test_done;
  end
  initial begin
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {fetch_req, fetch_dual, fr_opcode_wr, cmd_buf_wr, ctl_go_set} = 5'h00;
    {suspend, flash_port_disable_set, strap_drv} = 3'h0;
    fetch_addr = 24'h000000;
    {fr_opcode_data, cmd_buf_data} = 16'h0000;
    {cmd_buf_idx, resp_rd_idx, command_length} = 10'h000;
    reset_run(1'b0, 1'b0);
    t_fetch;
    t_dual;
    t_cmd;
    t_disable;
    reset_run(1'b1, 1'b1);
    fetch(24'h004000, 1'b0);
    chk(fetch_data === 8'h5A, "fast");
    reset_run(1'b0, 1'b1);
    test_done;
  end
endmodule // sffc_ctrl_bench

// [sim/sffc_ctrl_monitor.sv]
`timescale 1ns/10ps
module sffc_ctrl_monitor (
  input wire mclk,
  input wire rst_n,
  input wire fetch_rdy,
  input wire boot_done,
  input wire flash_port_disable_set,
  input wire flash_port_disabled,
  input wire ctl_go_set,
  input wire ctl_busy,
  input wire suspend,
  input wire flash_cs_n,
  input wire flash_sck,
  input wire flash_do_o,
  input wire flash_speed_strap_o,
  input wire flash_speed_strap_oe,
  input wire speed_fast
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> flash_cs_n
    && !flash_sck && !flash_speed_strap_oe && !ctl_busy && !fetch_rdy)
    else $error("outputs not idle in reset");
  a_sck_with_cs: assert property (flash_sck |-> !flash_cs_n)
    else $error("serial clock high with chip select high");
  a_do_steady_high: assert property (flash_sck && $past(flash_sck) |-> $stable(flash_do_o))
    else $error("serial out changed while clock high");
  a_slow_half: assert property ($rose(flash_sck) && !speed_fast |-> flash_sck[*4] ##1 !flash_sck)
    else $error("slow half period wrong");
  a_fast_half: assert property ($rose(flash_sck) && speed_fast |-> flash_sck[*2] ##1 !flash_sck)
    else $error("fast half period wrong");
  a_rdy_one_cycle: assert property (fetch_rdy |=> !fetch_rdy)
    else $error("ready longer than one cycle");
  a_rdy_after_boot: assert property (fetch_rdy |-> boot_done)
    else $error("ready before boot finished");
  a_busy_from_go: assert property ($rose(ctl_busy) |-> $past(ctl_go_set))
    else $error("busy without launch");
  a_busy_end_cs: assert property ($fell(ctl_busy) |-> flash_cs_n)
    else $error("chip select low after command end");
  a_disable_cause: assert property ($rose(flash_port_disabled) |-> $past(flash_port_disable_set))
    else $error("port disabled without request");
  a_disable_sticky: assert property (flash_port_disabled |=> flash_port_disabled)
    else $error("port disable lost");
  // three edges out of reset so the strap latch and pin drive have settled
  a_strap_drive: assert property ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3)
    && $stable(suspend) |-> flash_speed_strap_oe == !(suspend && speed_fast)
    && (!flash_speed_strap_oe || flash_speed_strap_o == speed_fast))
    else $error("strap pin drive wrong");
  a_strap_hold: assert property ($past(rst_n) && $past(rst_n, 2) |-> $stable(speed_fast))
    else $error("latched speed changed");
  c_fetch: cover property (fetch_rdy);
  c_cmd_end: cover property ($fell(ctl_busy));
  c_disabled: cover property ($rose(flash_port_disabled));
  c_fast: cover property ($rose(flash_sck) && speed_fast);
endmodule // sffc_ctrl_monitor

bind sffc_ctrl sffc_ctrl_monitor i_sffc_ctrl_monitor (.*);

// [sim/sffc_flash_model.sv]
`timescale 1ns/10ps
module sffc_flash_model (
  input  wire flash_cs_n,
  input  wire flash_sck,
  input  wire flash_do_o,
  input  wire dual,
  output reg  serial_in,
  output reg  io0
);
  reg     [7:0]  op;
  reg     [23:0] ad;
  reg     [63:0] rx;
  reg     [7:0]  b;
  integer        n, frames, k, p;
  function [7:0] mem(input [23:0] a);
    case (a)
      24'h00FFFA: mem = 8'h32;
      24'h00FFFB: mem = 8'h44;
      24'h00FFFC: mem = 8'h46;
      24'h00FFFD: mem = 8'h55;
      default: mem = a[7:0] ^ 8'h5A;
    endcase
  endfunction
  initial begin
    n = 0;
    frames = 0;
    serial_in = 1'b0;
    io0 = 1'b0;
  end
  always @(negedge flash_cs_n) begin
    n = 0;
    frames = frames + 1;
  end
  // released lines flip so a stale bit never passes
  always @(posedge flash_cs_n) begin
    serial_in = ~serial_in;
    io0 = ~io0;
  end
  always @(posedge flash_sck) begin
    rx = {rx[62:0], flash_do_o};
    if (n < 8) op = {op[6:0], flash_do_o};
    else if (n < 32) ad = {ad[22:0], flash_do_o};
    n = n + 1;
  end
  always @(negedge flash_sck) begin
    serial_in = ~serial_in;
    io0 = ~io0;
    if ((op == 8'h0B || dual) && n >= 40) begin
      k = dual ? (n - 40) / 4 : (n - 40) / 8;
      p = dual ? 2 * ((n - 40) % 4) : (n - 40) % 8;
      b = mem(ad + k);
      serial_in = b[7 - p];
      if (dual) io0 = b[6 - p];
    end else if (!(op == 8'h0B || dual) && n >= 8) begin
      b = 8'hB0 + (n - 8) / 8;
      serial_in = b[7 - (n - 8) % 8];
    end
  end
endmodule // sffc_flash_model
